// ===== src/rstb_cfg.svh
`ifndef RSTB_CFG_SVH
`define RSTB_CFG_SVH

// register byte offsets
`define RSTB_OFS_CTRL      8'h00
`define RSTB_OFS_UID       8'h04
`define RSTB_OFS_STATE     8'h08
`define RSTB_OFS_COUNTER   8'h0c
`define RSTB_OFS_LAST      8'h10

// control field positions and reset values
`define RSTB_CTRL_VARIANT  0
`define RSTB_CTRL_RESET    32'h0000_0001

// state field positions
`define RSTB_ST_SECURE     0
`define RSTB_ST_BUSY       1

// telegram type codes
`define RSTB_TYPE_SWITCH   8'hf6
`define RSTB_TYPE_SECURE   8'h31
`define RSTB_TYPE_TEACH    8'h35

// status field layout
`define RSTB_STAT_VARIANT  5
`define RSTB_STAT_MSG      4
`define RSTB_RPT_ORIGINAL  4'h0

// telegram lengths in bytes
`define RSTB_LEN_STANDARD  4'h7
`define RSTB_LEN_SECURE    4'ha
`define RSTB_LEN_TEACH     4'h9

// bus responses
`define RSTB_RESP_OKAY     2'h0
`define RSTB_RESP_DECERR   2'h3

`endif

// ===== src/rstb_pkg.sv
package rstb_pkg;

  // telegram builder states
  typedef enum logic [2:0] {
    RSTB_IDLE = 3'b001,
    RSTB_LOAD = 3'b010,
    RSTB_SEND = 3'b100
  } rstb_state_t;

  // operating mode
  typedef enum logic {
    RSTB_STANDARD = 1'b0,
    RSTB_SECURE   = 1'b1
  } rstb_mode_t;

  // inputs caught at an energy pulse; pressed[0..3] = a_on, a_off, b_on, b_off
  typedef struct packed {
    logic [3:0] pressed;
    logic       pol_rev;
    logic       sec_strap;
    logic       std_strap;
  } rstb_sample_t;

  // encoded switch data
  typedef struct packed {
    logic [7:0] data;
    logic       normal;
  } rstb_enc_t;

endpackage

// ===== src/rstb_data_enc.sv
`timescale 1ns/1ps
`default_nettype none

module rstb_data_enc (
  // sampled buttons
  input  wire logic [3:0]       pressed,
  input  wire logic             pol_rev,
  // encoded data byte
  output rstb_pkg::rstb_enc_t   enc
);

  logic [2:0] cnt;
  logic [1:0] first;
  logic [1:0] second;

  // count presses, lowest and highest pressed button code
  always_comb begin
    cnt    = 3'h0;
    first  = 2'h0;
    second = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (pressed[i]) begin
        cnt    = cnt + 3'h1;
        second = 2'(i);
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (pressed[i]) begin
        first = 2'(i);
      end
    end
  end

  // one or two presses give a normal message, else a count message
  always_comb begin
    enc.normal = (cnt == 3'h1) || (cnt == 3'h2);
    if (enc.normal) begin
      enc.data = {1'b0, first, ~pol_rev, 1'b0, second, cnt == 3'h2};
    end else begin
      // count codes 1 and 2 cannot arise on this branch
      enc.data = {cnt, pol_rev, 4'h0};
    end
  end

endmodule // rstb_data_enc

`default_nettype wire

// ===== src/rstb_roll_code.sv
`timescale 1ns/1ps
`default_nettype none

module rstb_roll_code #(
  parameter int          ROUNDS = 4,
  parameter logic [31:0] KEY    = 32'h6a09_e667
) (
  // mixing inputs
  input  wire logic [31:0] counter,
  input  wire logic [31:0] uid,
  input  wire logic [7:0]  data,
  // rolling code
  output logic      [31:0] code
);

  logic [31:0] x;

  // a cheap keyed mix; two counter values can give the same code
  always_comb begin
    x = counter ^ uid;
    for (int r = 0; r < ROUNDS; r++) begin
      x = {x[24:0], x[31:25]} ^ (x + {24'h0, data} + KEY);
    end
    code = x;
  end

endmodule // rstb_roll_code

`default_nettype wire

// ===== src/rstb_top.sv
// Behaviour
// - secure strap high at a pulse switches the mode to enhanced security; the code stays in standard mode if the standard strap is also high
// - standard strap high at a pulse switches the mode to standard telegrams
// - standard mode after reset until a strap changes it
// - entering secure mode sends teach-in, repeated each pulse while strap held
// - four active-low rocker inputs, grounded means pressed, open means released
// - standard telegram is seven bytes: type, data, four id, status, msb first
// - standard telegram type byte is always the repeated-switch code
// - four-byte unique identifier goes in every telegram's identifier field
// - status bit 5 selects the telegram variant, one meaning second variant
// - status bit 4 is one for normal, zero for count messages
// - status bits 3 to 0 hold the repeater level
// - one or two pressed buttons encode as a normal message
// - none, three or four pressed buttons encode as a count message
// - count data bits 7 to 5 hold the count, never one or two
// - count data bit 4 is zero for first input positive, else one
// - secure telegrams carry a rolling code from an incrementing counter
// - teach-in telegram carries the current rolling counter value
// - secure telegrams omit the counter; counter advances once per secure telegram
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "rstb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rstb_top #(
  parameter logic [31:0] UID_DEFAULT  = 32'h0123_4567,  // arbitrary value
  parameter logic [31:0] COUNTER_INIT = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // energy pulse and harvester polarity
  input  wire logic        energy_pulse,
  input  wire logic        harvest_input_first,
  input  wire logic        harvest_input_second,
  // rocker inputs, low when grounded
  input  wire logic        rocker_a_on_button_n,
  input  wire logic        rocker_a_off_button_n,
  input  wire logic        rocker_b_on_button_n,
  input  wire logic        rocker_b_off_button_n,
  // mode straps, high when tied to the mode supply
  input  wire logic        secure_strap,
  input  wire logic        standard_strap,
  // telegram byte stream
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic             secure_mode,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // telegram state
  rstb_pkg::rstb_state_t  state_reg,   state_next;
  rstb_pkg::rstb_mode_t   mode_reg,    mode_next;
  rstb_pkg::rstb_sample_t sample_reg,  sample_next;
  logic                   teach_reg,   teach_next;
  logic [31:0]            counter_reg, counter_next;
  logic [79:0]            frame_reg,   frame_next;
  logic [3:0]             left_reg,    left_next;
  logic                   valid_reg,   valid_next;
  logic                   last_reg,    last_next;
  logic [15:0]            lastds_reg,  lastds_next;

  // register file
  logic [31:0]            ctrl_reg,    ctrl_next;
  logic [31:0]            uid_reg,     uid_next;

  // bus slave state
  logic                   aw_full_reg, aw_full_next;
  logic                   w_full_reg,  w_full_next;
  logic [7:0]             awaddr_reg,  awaddr_next;
  logic [31:0]            wdata_reg,   wdata_next;
  logic [3:0]             wstrb_reg,   wstrb_next;
  logic                   awready_reg, awready_next;
  logic                   wready_reg,  wready_next;
  logic                   bvalid_reg,  bvalid_next;
  logic [1:0]             bresp_reg,   bresp_next;
  logic                   arready_reg, arready_next;
  logic                   rvalid_reg,  rvalid_next;
  logic [31:0]            rdata_reg,   rdata_next;
  logic [1:0]             rresp_reg,   rresp_next;

  rstb_pkg::rstb_enc_t    enc;
  logic [31:0]            roll_code;
  logic [7:0]             status_byte;
  logic                   wr_fire;

  // switch data from the sampled buttons
  rstb_data_enc u_enc (
    .pressed (sample_reg.pressed),
    .pol_rev (sample_reg.pol_rev),
    .enc     (enc)
  );

  // rolling code for the current counter
  rstb_roll_code u_roll (
    .counter (counter_reg),
    .uid     (uid_reg),
    .data    (enc.data),
    .code    (roll_code)
  );

  // status byte; only originals are sent, so the level is fixed
  always_comb begin
    status_byte                     = 8'h00;
    status_byte[`RSTB_STAT_VARIANT] = ctrl_reg[`RSTB_CTRL_VARIANT];
    status_byte[`RSTB_STAT_MSG]     = enc.normal;
    status_byte[3:0]                = `RSTB_RPT_ORIGINAL;
  end

  // telegram sequencer next state
  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    sample_next  = sample_reg;
    teach_next   = teach_reg;
    counter_next = counter_reg;
    frame_next   = frame_reg;
    left_next    = left_reg;
    valid_next   = valid_reg;
    last_next    = last_reg;
    lastds_next  = lastds_reg;
    unique case (state_reg)
      rstb_pkg::RSTB_IDLE: begin
        // pulses during a telegram are dropped; the pulse is the power-up
        if (energy_pulse) begin
          sample_next.pressed   = ~{rocker_b_off_button_n, rocker_b_on_button_n,
                                    rocker_a_off_button_n, rocker_a_on_button_n};
          sample_next.pol_rev   = harvest_input_second & ~harvest_input_first;
          sample_next.sec_strap = secure_strap;
          sample_next.std_strap = standard_strap;
          state_next            = rstb_pkg::RSTB_LOAD;
        end
      end
      rstb_pkg::RSTB_LOAD: begin
        // standard strap wins if both are tied
        teach_next = 1'b0;
        if (sample_reg.std_strap) begin
          mode_next = rstb_pkg::RSTB_STANDARD;
        end else if (sample_reg.sec_strap) begin
          mode_next  = rstb_pkg::RSTB_SECURE;
          teach_next = 1'b1;
        end
        if (teach_next) begin
          // teach-in carries the counter and leaves it as is
          frame_next = {`RSTB_TYPE_TEACH, counter_reg, uid_reg, 8'h00};
          left_next  = `RSTB_LEN_TEACH;
        end else if (mode_next == rstb_pkg::RSTB_SECURE) begin
          frame_next   = {`RSTB_TYPE_SECURE, enc.data, uid_reg, roll_code};
          left_next    = `RSTB_LEN_SECURE;
          counter_next = counter_reg + 32'h1;
        end else begin
          frame_next = {`RSTB_TYPE_SWITCH, enc.data, uid_reg, status_byte, 24'h0};
          left_next  = `RSTB_LEN_STANDARD;
        end
        lastds_next = {status_byte, enc.data};
        valid_next  = 1'b1;
        last_next   = 1'b0;
        state_next  = rstb_pkg::RSTB_SEND;
      end
      rstb_pkg::RSTB_SEND: begin
        // most significant byte first, held until taken
        if (tx_ready) begin
          frame_next = {frame_reg[71:0], 8'h00};
          left_next  = left_reg - 4'h1;
          last_next  = (left_reg == 4'h2);
          if (left_reg == 4'h1) begin
            valid_next = 1'b0;
            state_next = rstb_pkg::RSTB_IDLE;
          end
        end
      end
      default: begin
        state_next = rstb_pkg::RSTB_IDLE;
        valid_next = 1'b0;
        last_next  = 1'b0;
      end
    endcase
  end

  // telegram sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= rstb_pkg::RSTB_IDLE;
      mode_reg    <= rstb_pkg::RSTB_STANDARD;
      sample_reg  <= '0;
      teach_reg   <= 1'b0;
      counter_reg <= COUNTER_INIT;
      frame_reg   <= 80'h0;
      left_reg    <= 4'h0;
      valid_reg   <= 1'b0;
      last_reg    <= 1'b0;
      lastds_reg  <= 16'h0;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      sample_reg  <= sample_next;
      teach_reg   <= teach_next;
      counter_reg <= counter_next;
      frame_reg   <= frame_next;
      left_reg    <= left_next;
      valid_reg   <= valid_next;
      last_reg    <= last_next;
      lastds_reg  <= lastds_next;
    end
  end

  // bus write path: address and data taken in either order
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    ctrl_next    = ctrl_reg;
    uid_next     = uid_reg;
    wr_fire      = aw_full_reg && w_full_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `RSTB_RESP_OKAY;
      unique case (awaddr_reg)
        `RSTB_OFS_CTRL: begin
          if (wstrb_reg[0]) begin
            ctrl_next[`RSTB_CTRL_VARIANT] = wdata_reg[`RSTB_CTRL_VARIANT];
          end
        end
        `RSTB_OFS_UID: begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_reg[b]) begin
              uid_next[8*b +: 8] = wdata_reg[8*b +: 8];
            end
          end
        end
        // read-only registers accept and ignore writes
        `RSTB_OFS_STATE, `RSTB_OFS_COUNTER, `RSTB_OFS_LAST: begin
        end
        default: bresp_next = `RSTB_RESP_DECERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
  end

  // bus read path: one read at a time
  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = `RSTB_RESP_OKAY;
      unique case (s_axi_araddr)
        `RSTB_OFS_CTRL:    rdata_next = ctrl_reg;
        `RSTB_OFS_UID:     rdata_next = uid_reg;
        `RSTB_OFS_STATE:   rdata_next = {30'h0, state_reg != rstb_pkg::RSTB_IDLE,
                                         mode_reg == rstb_pkg::RSTB_SECURE};
        `RSTB_OFS_COUNTER: rdata_next = counter_reg;
        `RSTB_OFS_LAST:    rdata_next = {16'h0, lastds_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `RSTB_RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  // bus and register file registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RSTB_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `RSTB_RESP_OKAY;
      ctrl_reg    <= `RSTB_CTRL_RESET;
      uid_reg     <= UID_DEFAULT;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctrl_reg    <= ctrl_next;
      uid_reg     <= uid_next;
    end
  end

  // outputs straight from flops
  assign tx_data       = frame_reg[79:72];
  assign tx_valid      = valid_reg;
  assign tx_last       = last_reg;
  assign secure_mode   = mode_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

endmodule // rstb_top

`default_nettype wire

// ===== tb/rstb_checker.sv
`include "rstb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rstb_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // pulse and straps
  input wire logic        energy_pulse,
  input wire logic        secure_strap,
  input wire logic        standard_strap,
  // telegram stream
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        secure_mode,
  // bus answers
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic       active_reg, active_next, accept;
  logic [3:0] idx_reg, idx_next, len;
  logic [7:0] type_reg, type_next, data_reg, data_next;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // busy from a taken pulse until the last byte leaves
  assign accept = energy_pulse && !active_reg;
  assign len = (type_reg == `RSTB_TYPE_SWITCH) ? `RSTB_LEN_STANDARD :
               (type_reg == `RSTB_TYPE_SECURE) ? `RSTB_LEN_SECURE : `RSTB_LEN_TEACH;
  always_comb begin
    active_next = active_reg | accept;
    idx_next = idx_reg;
    type_next = type_reg;
    data_next = data_reg;
    if (tx_valid && tx_ready) begin
      idx_next = idx_reg + 4'h1;
      if (idx_reg == 4'h0) type_next = tx_data;
      if (idx_reg == 4'h1) data_next = tx_data;
      if (tx_last) begin
        idx_next = 4'h0;
        active_next = 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_reg <= 1'b0;
      idx_reg <= 4'h0;
      type_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      active_reg <= active_next;
      idx_reg <= idx_next;
      type_reg <= type_next;
      data_reg <= data_next;
    end
  end

  a_std_pulse: assert property (accept && standard_strap |-> ##2 tx_valid &&
    tx_data == `RSTB_TYPE_SWITCH && !secure_mode) else $error("standard pulse answer wrong");
  a_sec_pulse: assert property (accept && secure_strap && !standard_strap |-> ##2
    tx_valid && tx_data == `RSTB_TYPE_TEACH && secure_mode) else $error("teach-in missing");
  a_plain_pulse: assert property (accept && !secure_strap && !standard_strap |-> ##2
    tx_valid && tx_data == (secure_mode ? `RSTB_TYPE_SECURE : `RSTB_TYPE_SWITCH))
    else $error("plain pulse type wrong");
  a_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
    && $stable(tx_last)) else $error("byte dropped before taken");
  a_idle_quiet: assert property (!active_reg |-> !tx_valid) else $error("byte without pulse");
  a_last_len: assert property (tx_valid |-> tx_last == (idx_reg != 4'h0 &&
    idx_reg == len - 4'h1)) else $error("telegram length wrong");
  a_status_fixed: assert property (tx_valid && idx_reg == 4'h6 && type_reg == 8'hf6 |->
    tx_data[7:6] == 2'b00 && tx_data[3:0] == `RSTB_RPT_ORIGINAL) else $error("status bad");
  a_count_data: assert property (tx_valid && idx_reg == 4'h6 && type_reg == 8'hf6 &&
    !tx_data[4] |-> data_reg[3:0] == 4'h0 && data_reg[7:5] inside {3'd0, 3'd3, 3'd4})
    else $error("count message data bad");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read answer dropped");

  c_teach: cover property (accept && secure_strap);
  c_stall: cover property (tx_valid && !tx_ready);
  c_secure_end: cover property (tx_last && type_reg == `RSTB_TYPE_SECURE);
endmodule // rstb_checker

bind rstb_top rstb_checker rstb_checker_i (
  .aclk, .aresetn, .energy_pulse, .secure_strap, .standard_strap, .tx_data, .tx_valid,
  .tx_last, .tx_ready, .secure_mode, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ===== tb/rstb_rx_model.sv
`include "rstb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rstb_rx_model (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // byte stream from the transmitter
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  output logic            tx_ready,
  // bench control and view
  input wire logic        stall_en,
  output logic     [79:0] frame,
  output logic     [3:0]  frame_len,
  output logic     [31:0] frame_count,
  output logic     [31:0] rx_counter
);
  logic [79:0] acc, full;
  logic [3:0]  cnt;

  assign full = {acc[71:0], tx_data};

  // random stalls stress the hold-until-taken path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
      acc <= 80'h0;
      cnt <= 4'h0;
      frame <= 80'h0;
      frame_len <= 4'h0;
      frame_count <= 32'h0;
      rx_counter <= 32'h0;
    end else begin
      tx_ready <= stall_en ? (($urandom % 3) != 0) : 1'b1;
      if (tx_valid && tx_ready) begin
        acc <= full;
        cnt <= cnt + 4'h1;
        if (tx_last) begin
          frame <= full;
          frame_len <= cnt + 4'h1;
          frame_count <= frame_count + 32'h1;
          acc <= 80'h0;
          cnt <= 4'h0;
          // lossless link: window never slips, no new teach-in
          if (cnt == 4'h8 && full[71:64] == `RSTB_TYPE_TEACH) rx_counter <= full[63:32];
          if (cnt == 4'h9 && full[79:72] == `RSTB_TYPE_SECURE) rx_counter <= rx_counter + 32'h1;
        end
      end
    end
  end
endmodule // rstb_rx_model
`default_nettype wire

// ===== tb/rstb_top_test.sv
`include "rstb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rstb_top_test;
  localparam logic [31:0] UID0 = 32'h5a3c_9612;  // arbitrary value
  localparam logic [31:0] CTR0 = 32'h0000_fff0;

  logic        aclk = 1'b0, aresetn = 1'b0, energy_pulse = 1'b0, stall_en = 1'b0;
  logic        harvest_input_first = 1'b1, harvest_input_second = 1'b0;
  logic [3:0]  btn_n = 4'hf;  // a_on, a_off, b_on, b_off; low means pressed
  logic        secure_strap = 1'b0, standard_strap = 1'b0;
  logic [7:0]  tx_data, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        tx_valid, tx_last, tx_ready, secure_mode;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [79:0] frame;
  logic [3:0]  frame_len;
  logic [31:0] frame_count, rx_counter;
  int          bad_count = 0, n_checks = 0;

  always #12.5 aclk = ~aclk;

  rstb_top #(.UID_DEFAULT(UID0), .COUNTER_INIT(CTR0)) rstb_top_i (
    .aclk, .aresetn, .energy_pulse, .harvest_input_first, .harvest_input_second,
    .rocker_a_on_button_n(btn_n[0]), .rocker_a_off_button_n(btn_n[1]),
    .rocker_b_on_button_n(btn_n[2]), .rocker_b_off_button_n(btn_n[3]),
    .secure_strap, .standard_strap, .tx_data, .tx_valid, .tx_last, .tx_ready, .secure_mode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  rstb_rx_model rstb_rx_model_i (
    .aclk, .aresetn, .tx_data, .tx_valid, .tx_last, .tx_ready, .stall_en, .frame,
    .frame_len, .frame_count, .rx_counter
  );

  // lowest and highest code for one or two presses, else the count
  function automatic logic [7:0] exp_data(input logic [3:0] p, input logic pol);
    int n = $countones(p), lo = 0, hi = 0;
    for (int i = 3; i >= 0; i--) if (p[i]) lo = i;
    for (int i = 0; i < 4; i++) if (p[i]) hi = i;
    if (n == 1 || n == 2) return {lo[2:0], ~pol, hi[2:0], n == 2};
    return {n[2:0], pol, 4'h0};
  endfunction

  function automatic logic [7:0] exp_stat(input logic [3:0] p, input logic variant);
    return {2'b00, variant, $countones(p) inside {1, 2}, `RSTB_RPT_ORIGINAL};
  endfunction

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok = 1'b0, w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one pulse, then wait for the whole telegram
  task automatic fire(input logic [3:0] p, input logic pol, input logic sec, input logic std);
    logic [31:0] n0;
    n0 = frame_count;
    @(posedge aclk);
    btn_n <= ~p;
    harvest_input_first <= ~pol;
    harvest_input_second <= pol;
    secure_strap <= sec;
    standard_strap <= std;
    energy_pulse <= 1'b1;
    @(posedge aclk);
    energy_pulse <= 1'b0;
    secure_strap <= 1'b0;
    standard_strap <= 1'b0;
    while (frame_count == n0) @(posedge aclk);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    close_out();
  end

  initial begin
    logic [31:0] rd, uid, code;
    logic [1:0]  resp;
    logic [3:0]  p;
    logic        pol, variant;
    void'($urandom(32'hbc93));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(secure_mode, 1'b0);
    axi_rd(`RSTB_OFS_CTRL, rd, resp);
    check(rd, `RSTB_CTRL_RESET);
    axi_rd(`RSTB_OFS_UID, rd, resp);
    check(rd, UID0);
    axi_rd(8'h20, rd, resp);
    check(resp, `RSTB_RESP_DECERR);
    axi_wr(8'h24, 32'h1, resp);
    check(resp, `RSTB_RESP_DECERR);
    stall_en <= 1'b1;
    variant = 1'b1;
    uid = UID0;
    // all button sets and polarities, then random
    for (int k = 0; k < 44; k++) begin
      p = (k < 32) ? k[3:0] : 4'($urandom);
      pol = (k < 32) ? k[4] : 1'($urandom);
      if (k == 36) axi_wr(`RSTB_OFS_CTRL, 32'h0, resp);
      if (k == 36) variant = 1'b0;
      if (k == 40) uid = $urandom;
      if (k == 40) axi_wr(`RSTB_OFS_UID, uid, resp);
      fire(p, pol, 1'b0, 1'b0);
      check(frame_len, `RSTB_LEN_STANDARD);
      check(frame, {24'h0, 8'hf6, exp_data(p, pol), uid, exp_stat(p, variant)});
    end
    axi_rd(`RSTB_OFS_LAST, rd, resp);
    check(rd, {16'h0, exp_stat(p, variant), exp_data(p, pol)});
    // teach-in repeats, counter kept
    repeat (2) begin
      fire(4'h0, 1'b0, 1'b1, 1'b0);
      check(frame, {8'h0, `RSTB_TYPE_TEACH, CTR0, uid});
      check(secure_mode, 1'b1);
    end
    axi_rd(`RSTB_OFS_STATE, rd, resp);
    check(rd, 32'h1);
    code = 32'h0;
    for (int j = 0; j < 4; j++) begin
      p = 4'($urandom);
      pol = 1'($urandom);
      fire(p, pol, 1'b0, 1'b0);
      check(frame[79:32], {`RSTB_TYPE_SECURE, exp_data(p, pol), uid});
      if (j > 0) check(frame[31:0] != code, 1'b1);
      code = frame[31:0];
    end
    axi_rd(`RSTB_OFS_COUNTER, rd, resp);
    check(rd, CTR0 + 32'd4);
    check(rx_counter, CTR0 + 32'd4);
    fire(4'h1, 1'b0, 1'b1, 1'b1);
    check(secure_mode, 1'b0);
    check(frame, {24'h0, 8'hf6, exp_data(4'h1, 1'b0), uid, exp_stat(4'h1, variant)});
    close_out();
  end
endmodule // rstb_top_test
`default_nettype wire
